// >>> src/fan_span_regs.vh
/*
 * Register map, field layout, reset value and rate and span tables
 * for the per-channel span and drive-rate configuration bank.
 * Assumes it is included by bare name by the design files.
 */
`ifndef FAN_SPAN_REGS_VH
`define FAN_SPAN_REGS_VH

`define ADDR_REMOTE1_SPAN_FAN1_RATE 8'h5f
`define ADDR_LOCAL_SPAN_FAN2_RATE 8'h60
`define ADDR_REMOTE2_SPAN_FAN3_RATE 8'h61
`define SPAN_RATE_RESET 8'hc4

`define RATE_SELECT_MSB 2
`define RATE_SELECT_LSB 0
`define OVERHEAT_ENABLE_BIT 3
`define SPAN_MSB 7
`define SPAN_LSB 4
`define RATE_SELECT_RESET 3'h4
`define SPAN_CODE_RESET 4'hc

`define CLK_HZ_DEFAULT 32'h017d7840

// Drive frequencies in hundredths of a hertz.
`define RATE0_CHZ 14'h044c
`define RATE1_CHZ 14'h05be
`define RATE2_CHZ 14'h08a2
`define RATE3_CHZ 14'h0b7c
`define RATE4_CHZ 14'h0dca
`define RATE5_CHZ 14'h113a
`define RATE6_CHZ 14'h16f8
`define RATE7_CHZ 14'h2274

// Temperature spans in hundredths of a degree Celsius.
`define SPAN0_CDEG 13'h00c8
`define SPAN1_CDEG 13'h00fa
`define SPAN2_CDEG 13'h014d
`define SPAN3_CDEG 13'h0190
`define SPAN4_CDEG 13'h01f4
`define SPAN5_CDEG 13'h029b
`define SPAN6_CDEG 13'h0320
`define SPAN7_CDEG 13'h03e8
`define SPAN8_CDEG 13'h0535
`define SPAN9_CDEG 13'h0640
`define SPAN10_CDEG 13'h07d0
`define SPAN11_CDEG 13'h0a6b
`define SPAN12_CDEG 13'h0c80
`define SPAN13_CDEG 13'h0fa0
`define SPAN14_CDEG 13'h14d5
`define SPAN15_CDEG 13'h1f40

// Overheat hold: number of monitoring-cycle boundaries seen after assertion.
`define OVERHEAT_HOLD_BOUNDARIES 2'h2

`endif

// >>> src/drive_rate_divider.v
/*
 * Fan drive period generator for one channel.
 * Assumes a synchronous active-high reset and a rate code from a register.
 */
`timescale 1ns/10ps
`include "fan_span_regs.vh"

module drive_rate_divider #(
	parameter CLK_HZ = `CLK_HZ_DEFAULT
) (
	input wire ref_clk,
	input wire srst,
	input wire [2:0] rate_code,
	output reg period_tick,
	output reg [2:0] applied_code
);

	reg [31:0] count_reg;

	function [31:0] period_cycles;
		input [2:0] code;
		reg [13:0] chz;
		reg [63:0] cyc;
		begin
			case (code)
				3'h0: chz = `RATE0_CHZ;
				3'h1: chz = `RATE1_CHZ;
				3'h2: chz = `RATE2_CHZ;
				3'h3: chz = `RATE3_CHZ;
				3'h4: chz = `RATE4_CHZ;
				3'h5: chz = `RATE5_CHZ;
				3'h6: chz = `RATE6_CHZ;
				default: chz = `RATE7_CHZ;
			endcase
			cyc = (CLK_HZ * 64'h64) / chz;
			if (cyc < 64'h1) begin
				cyc = 64'h1;
			end
			period_cycles = cyc[31:0];
		end
	endfunction

	// The code is only taken at the wrap, so a period is never cut short.
	always @(posedge ref_clk) begin
		if (srst) begin
			count_reg <= 32'h0;
			applied_code <= `RATE_SELECT_RESET;
			period_tick <= 1'b0;
		end else if (count_reg >= period_cycles(applied_code) - 32'h1) begin
			count_reg <= 32'h0;
			applied_code <= rate_code;
			period_tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 32'h1;
			period_tick <= 1'b0;
		end
	end

endmodule // drive_rate_divider

// >>> src/overheat_channel.v
/*
 * Over-temperature assertion tracker for one temperature channel.
 * Assumes temperature in quarter degrees and a limit in whole degrees.
 */
`timescale 1ns/10ps
`include "fan_span_regs.vh"

module overheat_channel (
	input wire ref_clk,
	input wire srst,
	input wire enable,
	input wire [9:0] temp_qdeg,
	input wire [7:0] limit_deg,
	input wire cycle_done,
	output reg active
);

	reg [1:0] seen_reg;
	wire [9:0] limit_qdeg;
	wire over;
	wire hold_done;

	assign limit_qdeg = {limit_deg, 2'b00};
	// One quarter degree above the limit is the first code strictly above it.
	assign over = temp_qdeg > limit_qdeg;
	assign hold_done = seen_reg == `OVERHEAT_HOLD_BOUNDARIES;

	always @(posedge ref_clk) begin
		if (srst) begin
			active <= 1'b0;
			seen_reg <= 2'h0;
		end else if (!enable) begin
			active <= 1'b0;
			seen_reg <= 2'h0;
		end else if (!active) begin
			if (over) begin
				active <= 1'b1;
				seen_reg <= 2'h0;
			end
		end else begin
			if (cycle_done && !hold_done) begin
				seen_reg <= seen_reg + 2'h1;
			end
			if (hold_done && !over) begin
				active <= 1'b0;
			end
		end
	end

endmodule // overheat_channel

// >>> src/fan_span_pwm_rate_config.v
/*
 * Per-channel temperature span and fan drive rate configuration bank,
 * with the over-temperature pin control for three channels.
 * Assumes the serial interface engine presents decoded register accesses,
 * and that the lock bit, temperatures, limits and the monitoring-cycle
 * strobe come from neighbouring logic on the same clock.
 */
// Behaviour
// - Once the lock bit is set, writes to all three registers are discarded.
// - Registers at 0x5f, 0x60, 0x61 pair remote 1, local, remote 2 with fans 1-3.
// - Every register powers up holding 0xc4.
// - Bits 2:0 select fan drive frequency, 11.0 Hz to 88.2 Hz, default 35.3 Hz.
// - With bit 3 and overheat_pin_mode set, pin is driven low once temperature exceeds limit by 0.25 C.
// - Once asserted, pin stays low until temperature is at or below the limit.
// - Assertion lasts at least one full monitoring cycle.
// - With bit 3 clear, the channel never drives the pin; the pin is an input.
// - Bits 7:4 set the span of the duty versus temperature slope; 0000 is 2 C.
// - Codes 0001 to 1111 give 2.5 up to 80 C, 32 C being the default.
`timescale 1ns/10ps
`include "fan_span_regs.vh"

module fan_span_pwm_rate_config #(
	parameter CLK_HZ = `CLK_HZ_DEFAULT
) (
	input wire ref_clk,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output reg reg_hit,
	output wire write_refused,
	input wire config_lock,
	input wire overheat_pin_mode,
	input wire [29:0] channel_temp_qdeg,
	input wire [23:0] channel_limit_deg,
	input wire monitor_cycle_done,
	input wire overheat_alarm_pin_in,
	output wire overheat_alarm_pin_out,
	output wire overheat_alarm_pin_oe,
	output reg processor_hot_signal,
	output wire [8:0] drive_rate_select,
	output wire [2:0] drive_period_tick,
	output wire [11:0] temperature_span,
	output reg [38:0] span_centi_deg,
	output wire [2:0] overheat_output_enable,
	output wire [2:0] overheat_active
);

	reg [7:0] remote1_span_fan1_rate_reg;
	reg [7:0] local_span_fan2_rate_reg;
	reg [7:0] remote2_span_fan3_rate_reg;
	reg pin_s1_reg;
	reg pin_s2_reg;
	reg pin_s3_reg;
	reg oe_s1_reg;
	reg oe_s2_reg;
	reg oe_s3_reg;
	wire hit;
	wire [7:0] read_mux;
	wire [23:0] all_regs;

	function [12:0] span_lookup;
		input [3:0] code;
		begin
			case (code)
				4'h0: span_lookup = `SPAN0_CDEG;
				4'h1: span_lookup = `SPAN1_CDEG;
				4'h2: span_lookup = `SPAN2_CDEG;
				4'h3: span_lookup = `SPAN3_CDEG;
				4'h4: span_lookup = `SPAN4_CDEG;
				4'h5: span_lookup = `SPAN5_CDEG;
				4'h6: span_lookup = `SPAN6_CDEG;
				4'h7: span_lookup = `SPAN7_CDEG;
				4'h8: span_lookup = `SPAN8_CDEG;
				4'h9: span_lookup = `SPAN9_CDEG;
				4'ha: span_lookup = `SPAN10_CDEG;
				4'hb: span_lookup = `SPAN11_CDEG;
				4'hc: span_lookup = `SPAN12_CDEG;
				4'hd: span_lookup = `SPAN13_CDEG;
				4'he: span_lookup = `SPAN14_CDEG;
				default: span_lookup = `SPAN15_CDEG;
			endcase
		end
	endfunction

	assign hit = (reg_addr == `ADDR_REMOTE1_SPAN_FAN1_RATE) ||
		(reg_addr == `ADDR_LOCAL_SPAN_FAN2_RATE) ||
		(reg_addr == `ADDR_REMOTE2_SPAN_FAN3_RATE);

	// A refused write is still reported so the host side can notice it.
	assign write_refused = reg_wr && hit && config_lock;

	always @(posedge ref_clk) begin
		if (srst) begin
			remote1_span_fan1_rate_reg <= `SPAN_RATE_RESET;
			local_span_fan2_rate_reg <= `SPAN_RATE_RESET;
			remote2_span_fan3_rate_reg <= `SPAN_RATE_RESET;
		end else if (reg_wr && !config_lock) begin
			if (reg_addr == `ADDR_REMOTE1_SPAN_FAN1_RATE) begin
				remote1_span_fan1_rate_reg <= reg_wdata;
			end else if (reg_addr == `ADDR_LOCAL_SPAN_FAN2_RATE) begin
				local_span_fan2_rate_reg <= reg_wdata;
			end else if (reg_addr == `ADDR_REMOTE2_SPAN_FAN3_RATE) begin
				remote2_span_fan3_rate_reg <= reg_wdata;
			end
		end
	end

	assign read_mux = (reg_addr == `ADDR_REMOTE1_SPAN_FAN1_RATE) ? remote1_span_fan1_rate_reg :
		(reg_addr == `ADDR_LOCAL_SPAN_FAN2_RATE) ? local_span_fan2_rate_reg :
		(reg_addr == `ADDR_REMOTE2_SPAN_FAN3_RATE) ? remote2_span_fan3_rate_reg : 8'h00;

	always @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
			reg_hit <= hit;
		end
	end

	assign all_regs = {remote2_span_fan3_rate_reg, local_span_fan2_rate_reg,
		remote1_span_fan1_rate_reg};

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : chan
			wire [7:0] cfg;
			assign cfg = all_regs[ch*8 +: 8];
			assign temperature_span[ch*4 +: 4] = cfg[`SPAN_MSB:`SPAN_LSB];
			assign overheat_output_enable[ch] = cfg[`OVERHEAT_ENABLE_BIT];

			drive_rate_divider #(
				.CLK_HZ(CLK_HZ)
			) divider (
				.ref_clk(ref_clk),
				.srst(srst),
				.rate_code(cfg[`RATE_SELECT_MSB:`RATE_SELECT_LSB]),
				.period_tick(drive_period_tick[ch]),
				.applied_code(drive_rate_select[ch*3 +: 3])
			);

			overheat_channel watch (
				.ref_clk(ref_clk),
				.srst(srst),
				.enable(cfg[`OVERHEAT_ENABLE_BIT] && overheat_pin_mode),
				.temp_qdeg(channel_temp_qdeg[ch*10 +: 10]),
				.limit_deg(channel_limit_deg[ch*8 +: 8]),
				.cycle_done(monitor_cycle_done),
				.active(overheat_active[ch])
			);
		end
	endgenerate

	// One process owns the whole span output, so every bit has a single driver.
	always @(posedge ref_clk) begin
		if (srst) begin
			span_centi_deg <= {3{span_lookup(`SPAN_CODE_RESET)}};
		end else begin
			span_centi_deg <= {span_lookup(temperature_span[11:8]),
				span_lookup(temperature_span[7:4]), span_lookup(temperature_span[3:0])};
		end
	end

	// Open drain, active low: only ever drive a zero.
	assign overheat_alarm_pin_out = 1'b0;
	assign overheat_alarm_pin_oe = |overheat_active;

	// The pin is asynchronous, so a change is accepted only once two stages agree.
	// Our own drive is remembered as long as it can linger in the stages, so that
	// releasing the pin is never mistaken for a low from outside.
	always @(posedge ref_clk) begin
		if (srst) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_s3_reg <= 1'b1;
			oe_s1_reg <= 1'b0;
			oe_s2_reg <= 1'b0;
			oe_s3_reg <= 1'b0;
			processor_hot_signal <= 1'b0;
		end else begin
			pin_s1_reg <= overheat_alarm_pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			oe_s1_reg <= overheat_alarm_pin_oe;
			oe_s2_reg <= oe_s1_reg;
			oe_s3_reg <= oe_s2_reg;
			if (pin_s2_reg == pin_s3_reg) begin
				processor_hot_signal <= overheat_pin_mode && !pin_s3_reg &&
					!overheat_alarm_pin_oe && !oe_s1_reg && !oe_s2_reg && !oe_s3_reg;
			end
		end
	end

endmodule // fan_span_pwm_rate_config

// >>> test/fan_span_checks_assertions.sv
/* Concurrent checks on the span and rate bank ports.
   Assumes it is bound to the bank by name. */
`timescale 1ns/10ps
module fan_span_checks (
	input wire ref_clk,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire reg_hit,
	input wire config_lock,
	input wire overheat_pin_mode,
	input wire [29:0] channel_temp_qdeg,
	input wire [23:0] channel_limit_deg,
	input wire monitor_cycle_done,
	input wire overheat_alarm_pin_oe,
	input wire [8:0] drive_rate_select,
	input wire [2:0] drive_period_tick,
	input wire [11:0] temperature_span,
	input wire [2:0] overheat_output_enable,
	input wire [2:0] overheat_active
);
	wire hot0 = channel_temp_qdeg[9:0] > {channel_limit_deg[7:0], 2'h0};
	// Monitoring-cycle ends seen while channel 0 holds its alarm, capped at two.
	logic [1:0] done_seen = 2'h0;
	always @(posedge ref_clk) begin
		if (srst || !overheat_active[0]) begin
			done_seen <= 2'h0;
		end else if (monitor_cycle_done && done_seen != 2'h2) begin
			done_seen <= done_seen + 2'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_lock_keeps_regs: assert property (reg_wr && config_lock |=>
		$stable({temperature_span, overheat_output_enable})) else $error("locked write landed");
	chk_unmapped_read: assert property (reg_rd && (reg_addr < 8'h5f || reg_addr > 8'h61) |=>
		reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read not zero");
	chk_reset_value: assert property ($fell(srst) |->
		temperature_span == 12'hccc && overheat_output_enable == 3'h0) else $error("bad reset");
	chk_rate_at_tick: assert property (!$stable(drive_rate_select) |->
		|drive_period_tick) else $error("rate changed off a period boundary");
	chk_pin_enable_or: assert property (overheat_alarm_pin_oe == |overheat_active &&
		(overheat_active & ~$past(overheat_output_enable)) == 3'h0 &&
		(!overheat_alarm_pin_oe || $past(overheat_pin_mode))) else $error("pin driven without enable");
	chk_alarm_rises: assert property (overheat_output_enable[0] && overheat_pin_mode
		&& hot0 |=> overheat_active[0]) else $error("alarm missed");
	chk_input_mode_quiet: assert property (!overheat_output_enable[0] |=>
		!overheat_active[0]) else $error("pin driven in input mode");
	chk_release_at_limit: assert property ($fell(overheat_active[0]) && !$past(srst)
		&& $past(overheat_output_enable[0]) && $past(overheat_pin_mode) |-> !$past(hot0))
		else $error("alarm released while hot");
	chk_hold_min: assert property ($fell(overheat_active[0]) && !$past(srst)
		&& $past(overheat_output_enable[0]) && $past(overheat_pin_mode) |-> $past(done_seen) == 2'h2)
		else $error("alarm released before a full monitoring cycle");
	cover property ($rose(overheat_active[0]));
	cover property (reg_wr && config_lock);
	cover property (drive_period_tick[1]);
endmodule // fan_span_checks

// >>> test/alarm_pin_partner.sv
/* Far side of the open-drain overheat pin: pull-up plus an outside driver.
   Assumes an active-high drive enable from the bank. */
`timescale 1ns/10ps
module alarm_pin_partner (
	input wire oe,
	input wire ext_low,
	output wire level
);
	// Either party pulling low wins, so a released pin reads high, never stale.
	assign level = !(oe || ext_low);
endmodule // alarm_pin_partner

// >>> test/fan_span_pwm_rate_config_bench.sv
/* Self-checking bench for the span and rate bank.
   Assumes the checker and the pin partner are compiled first. */
`timescale 1ns/10ps
module fan_span_pwm_rate_config_bench;
	logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, config_lock = 0, pend = 0;
	logic overheat_pin_mode = 0, monitor_cycle_done = 0, ext_hot = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [29:0] channel_temp_qdeg = 30'h0;
	logic [23:0] channel_limit_deg = 24'h32;
	wire [7:0] reg_rdata;
	wire reg_hit, write_refused, overheat_alarm_pin_in, overheat_alarm_pin_out;
	wire overheat_alarm_pin_oe, processor_hot_signal;
	wire [8:0] drive_rate_select;
	wire [2:0] drive_period_tick, overheat_output_enable, overheat_active;
	wire [11:0] temperature_span;
	wire [38:0] span_centi_deg;
	int failures = 0, cmp_count = 0, n;
	logic [8:0] q[$];
	logic [7:0] vals[3], d;
	// Drive periods in cycles for the short divider base, slowest rate first.
	logic [7:0] per[8] = '{8'h5a, 8'h44, 8'h2d, 8'h22, 8'h1c, 8'h16, 8'h11, 8'h0b};
	logic [12:0] tab[16] = '{13'h0c8, 13'h0fa, 13'h14d, 13'h190, 13'h1f4, 13'h29b, 13'h320,
		13'h3e8, 13'h535, 13'h640, 13'h7d0, 13'ha6b, 13'hc80, 13'hfa0, 13'h14d5, 13'h1f40};
	// A short divider base keeps every drive period under a hundred cycles.
	fan_span_pwm_rate_config #(.CLK_HZ(1000)) i_dut (.*);
	alarm_pin_partner i_pin (.oe(overheat_alarm_pin_oe), .ext_low(ext_hot),
		.level(overheat_alarm_pin_in));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) pend <= reg_rd;
	always @(negedge ref_clk) if (pend) check({reg_hit, reg_rdata}, q.pop_front());
	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task step;
		@(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		step;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1;
		step;
		check(write_refused, config_lock && a >= 8'h5f && a <= 8'h61);
		reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		step;
		reg_addr = a;
		reg_rd = 1;
		q.push_back({a >= 8'h5f && a <= 8'h61, e});
		step;
		reg_rd = 0;
	endtask
	task pulse;
		step;
		monitor_cycle_done = 1;
		step;
		monitor_cycle_done = 0;
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#800000;
		failures++;
		finish_test;
	end
	initial begin
		d = $urandom(32'hf22a);
		repeat (12) step;
		srst = 0;
		for (int i = 0; i < 3; i++) rd(8'(8'h5f + i), 8'hc4);
		rd(8'h62, 8'h00);
		rd(8'h5e, 8'h00);
		check(span_centi_deg[38:26], 13'hc80);
		check(drive_rate_select, 9'h124);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			vals[i] = 8'($urandom);
			wr(8'(8'h5f + i), vals[i]);
			rd(8'(8'h5f + i), vals[i]);
		end
		$display("test readback done");
		for (int i = 0; i < 16; i++) begin
			wr(8'h60, {i[3:0], 1'b0, i[2:0]});
			n = 0;
			do begin
				step;
				n++;
			end while (drive_period_tick[1] !== 1'b1 && n < 200);
			check(drive_period_tick[1], 1'b1);
			check(drive_rate_select[5:3], i[2:0]);
			n = 0;
			do begin
				step;
				n++;
			end while (drive_period_tick[1] !== 1'b1 && n < 200);
			check(16'(n), per[i[2:0]]);
			repeat (2) step;
			check(temperature_span[7:4], i[3:0]);
			check(span_centi_deg[25:13], tab[i]);
		end
		vals[1] = 8'hf7;
		$display("test span and rate done");
		config_lock = 1;
		for (int i = 0; i < 3; i++) wr(8'(8'h5f + i), ~vals[i]);
		for (int i = 0; i < 3; i++) rd(8'(8'h5f + i), vals[i]);
		config_lock = 0;
		$display("test lock done");
		overheat_pin_mode = 1;
		channel_temp_qdeg[9:0] = 10'h0c8;
		wr(8'h5f, 8'hcc);
		repeat (3) step;
		check(overheat_active[0], 1'b0);
		channel_temp_qdeg[9:0] = 10'h0c9;
		repeat (2) step;
		check(overheat_alarm_pin_in, 1'b0);
		check(overheat_alarm_pin_out, 1'b0);
		channel_temp_qdeg[9:0] = 10'h0c8;
		repeat (3) step;
		check(overheat_active[0], 1'b1);
		channel_temp_qdeg[9:0] = 10'h0c9;
		pulse;
		pulse;
		repeat (3) step;
		check(overheat_active[0], 1'b1);
		channel_temp_qdeg[9:0] = 10'h0c8;
		repeat (3) step;
		check(overheat_alarm_pin_in, 1'b1);
		check(processor_hot_signal, 1'b0);
		$display("test alarm output done");
		wr(8'h5f, 8'hc4);
		channel_temp_qdeg[9:0] = 10'h0c9;
		ext_hot = 1;
		repeat (5) step;
		check(overheat_alarm_pin_oe, 1'b0);
		check(processor_hot_signal, 1'b1);
		ext_hot = 0;
		repeat (5) step;
		check(processor_hot_signal, 1'b0);
		$display("test alarm input done");
		finish_test;
	end
endmodule // fan_span_pwm_rate_config_bench
bind fan_span_pwm_rate_config fan_span_checks i_chk (.*);
